/* File: rtl/rdmpd_responder.sv */
// Responder for parameter description and device information requests
// Contract
// - Description ACK: PID, size, type, class, type, unit, prefix, limits, text.
// - Size byte gives data length for GET and SET; max string length for text.
// - Data type byte is enumerated width and signedness code.
// - Command class byte tells whether GET, SET or both exist.
// - Obsolete type byte is sent as zero; controller ignores it.
// - Unit byte is an 8-bit enumerated SI unit code.
// - Prefix byte is an 8-bit enumerated SI prefix code.
// - Limits are 32 bits; narrower data types get zero upper bytes.
// - Limits mean nothing for bit-field or text types.
// - Reported default lies between minimum and maximum inclusive.
// - Label is 0 to 32 characters; length shrinks with it.
// - Device info ACK has 0x13 bytes in the documented field order.
// - Protocol version reports major 0x01 in high byte, minor 0x00 low.
// - Protocol version is the same for root and every sub-device.
// - Model field identifies the addressed root or sub-device model.
module rdmpd_responder #(
   parameter int LABEL_CHARS = 32
) (
   input wire logic sys_clk,                 // 40 MHz system clock
   input wire logic arst_n,                  // Async reset, active low
   input wire logic req_valid,               // Parsed GET request present
   output logic req_ready,                   // Request accepted
   input wire logic [15:0] req_pid,          // Requested parameter
   input wire logic [7:0] req_pdl,           // Request data length
   input wire logic [7:0] req_msg_count,     // Request message count
   input wire logic [15:0] req_subdev,       // Request sub-device
   input wire logic [15:0] req_data,         // First two parameter data bytes
   output logic [15:0] desc_pid,             // Parameter to look up
   input wire logic desc_known,              // Parameter is described
   input wire logic [7:0] desc_size,         // Data length of parameter
   input wire logic [7:0] desc_type,         // Data type code
   input wire logic [7:0] desc_class,        // Command class code
   input wire logic [7:0] desc_unit,         // Unit code
   input wire logic [7:0] desc_prefix,       // Prefix code
   input wire logic [31:0] desc_min,         // Minimum value
   input wire logic [31:0] desc_max,         // Maximum value
   input wire logic [31:0] desc_default,     // Default value
   input wire logic [5:0] desc_label_len,    // Label length in characters
   input wire logic [LABEL_CHARS*8-1:0] desc_label, // Label, first char in top bits
   input wire logic [15:0] info_model,       // Model of addressed device
   input wire logic [15:0] info_category,    // Product category
   input wire logic [31:0] info_sw_version,  // Software version
   input wire logic [15:0] info_footprint,   // Slot footprint
   input wire logic [15:0] info_personality, // Personality pair
   input wire logic [15:0] info_start_addr,  // Start address
   input wire logic [15:0] info_subdev_count, // Sub-device count
   input wire logic [7:0] info_sensor_count, // Sensor count
   output logic rsp_start,                   // Answer begins, one-cycle pulse
   output logic [1:0] rsp_status,            // Answer status code
   output logic [7:0] rsp_pdl,               // Answer data length
   output logic rsp_valid,                   // Data byte valid
   input wire logic rsp_ready,               // Framer takes byte
   output logic [7:0] rsp_byte,              // Data byte
   output logic rsp_last                     // Final data byte
);
   localparam int NB = 20 + LABEL_CHARS;

   typedef enum logic [1:0] {RDMPD_IDLE, RDMPD_START, RDMPD_SEND} rdmpd_state_t;

   // ==========================================
   // State and captured answer
   rdmpd_state_t state, next_state;
   logic [NB*8-1:0] record, next_record;
   logic [7:0] length, next_length;
   logic [7:0] index, next_index;
   logic [1:0] status, next_status;
   logic [7:0] sel_byte;
   logic [7:0] sel_byte_next;
   logic [7:0] out_byte, next_out_byte;
   logic [31:0] lim_min, lim_max, lim_def;
   logic [5:0] label_len;
   logic is_desc, is_info, pid_ok, info_ok;

   assign desc_pid = req_data;
   // One answer at a time; requests wait while an answer is in flight
   assign req_ready = (state == RDMPD_IDLE);

   // ==========================================
   // Limit fields, masked to the data width
   function automatic logic [31:0] rdmpd_fit(input logic [7:0] dtype, input logic [31:0] v);
      case (dtype)
         rdmpd_pkg::DS_BITFIELD, rdmpd_pkg::DS_TEXT: rdmpd_fit = 32'h0000_0000;
         rdmpd_pkg::DS_U8, rdmpd_pkg::DS_S8: rdmpd_fit = {24'h000000, v[7:0]};
         rdmpd_pkg::DS_U16, rdmpd_pkg::DS_S16: rdmpd_fit = {16'h0000, v[15:0]};
         default: rdmpd_fit = v;
      endcase
   endfunction

   always_comb begin
      lim_min = rdmpd_fit(desc_type, desc_min);
      lim_max = rdmpd_fit(desc_type, desc_max);
      lim_def = rdmpd_fit(desc_type, desc_default);
      // Default clamped into the reported range, compared unsigned
      if (lim_def < lim_min) begin
         lim_def = lim_min;
      end else if (lim_def > lim_max) begin
         lim_def = lim_max;
      end
      label_len = (desc_label_len > rdmpd_pkg::LABEL_MAX) ? rdmpd_pkg::LABEL_MAX
                                                          : desc_label_len;
      if (32'(label_len) > LABEL_CHARS) begin
         label_len = 6'(LABEL_CHARS);
      end
   end

   // ==========================================
   // Request checks
   always_comb begin
      is_desc = (req_pid == rdmpd_pkg::PID_PARAM_DESC);
      is_info = (req_pid == rdmpd_pkg::PID_DEVICE_INFO);
      pid_ok = (req_pdl == rdmpd_pkg::REQ_PDL_DESC) && (req_data >= rdmpd_pkg::MS_PID_LO)
               && (req_data <= rdmpd_pkg::MS_PID_HI) && desc_known;
      info_ok = (req_pdl == rdmpd_pkg::REQ_PDL_INFO)
                && (req_msg_count == rdmpd_pkg::REQ_MSG_COUNT)
                && (req_subdev <= rdmpd_pkg::SUBDEV_MAX);
   end

   // ==========================================
   // Sequencer
   always_comb begin
      next_state = state;
      next_record = record;
      next_length = length;
      next_index = index;
      next_status = status;
      next_out_byte = out_byte;
      case (state)
         RDMPD_IDLE: begin
            if (req_valid && (is_desc || is_info)) begin
               next_state = RDMPD_START;
               next_index = 8'h00;
               next_status = rdmpd_pkg::ST_ACK;
               next_length = 8'h00;
               next_record = '0;
               if (is_desc && !pid_ok) begin
                  next_status = (req_pdl != rdmpd_pkg::REQ_PDL_DESC) ?
                                rdmpd_pkg::ST_NACK_FORMAT : rdmpd_pkg::ST_NACK_RANGE;
               end else if (is_info && !info_ok) begin
                  next_status = rdmpd_pkg::ST_NACK_FORMAT;
               end else if (is_desc) begin
                  // Fields packed most significant byte first
                  next_record[NB*8-1 -: 160] = {req_data, desc_size, desc_type, desc_class,
                     rdmpd_pkg::OBSOLETE_TYPE, desc_unit, desc_prefix,
                     lim_min, lim_max, lim_def};
                  for (int c = 0; c < LABEL_CHARS; c++) begin
                     next_record[(LABEL_CHARS-1-c)*8 +: 8] = (6'(c) < label_len) ?
                        desc_label[(LABEL_CHARS-1-c)*8 +: 8] : 8'h00;
                  end
                  next_length = rdmpd_pkg::DESC_FIXED_LEN + {2'b00, label_len};
               end else begin
                  next_record[NB*8-1 -: 152] = {rdmpd_pkg::PROTO_MAJOR, rdmpd_pkg::PROTO_MINOR,
                     info_model, info_category, info_sw_version, info_footprint,
                     info_personality, info_start_addr, info_subdev_count,
                     info_sensor_count};
                  next_length = rdmpd_pkg::INFO_LEN;
               end
            end
         end
         RDMPD_START: begin
            next_out_byte = sel_byte;
            next_state = (length == 8'h00) ? RDMPD_IDLE : RDMPD_SEND;
         end
         RDMPD_SEND: begin
            // Following byte is fetched ahead so the output stays registered
            if (rsp_ready) begin
               next_index = index + 8'h01;
               next_out_byte = record[(NB-1)*8 +: 8];
               if (index + 8'h01 >= length) begin
                  next_state = RDMPD_IDLE;
               end else begin
                  next_out_byte = sel_byte_next;
               end
            end
         end
         default: next_state = RDMPD_IDLE;
      endcase
   end

   // ==========================================
   // Byte pickers for the current and the following position
   rdmpd_byte_mux #(.NBYTES(NB)) u_mux_cur (
      .record(record),
      .index(index),
      .data(sel_byte)
   );
   rdmpd_byte_mux #(.NBYTES(NB)) u_mux_next (
      .record(record),
      .index(index + 8'h01),
      .data(sel_byte_next)
   );

   // ==========================================
   // Registers
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= RDMPD_IDLE;
         record <= '0;
         length <= 8'h00;
         index <= 8'h00;
         status <= rdmpd_pkg::ST_ACK;
         out_byte <= 8'h00;
      end else begin
         state <= next_state;
         record <= next_record;
         length <= next_length;
         index <= next_index;
         status <= next_status;
         out_byte <= next_out_byte;
      end
   end

   // ==========================================
   // Answer outputs
   assign rsp_start = (state == RDMPD_START);
   assign rsp_status = status;
   assign rsp_pdl = length;
   assign rsp_valid = (state == RDMPD_SEND);
   assign rsp_byte = out_byte;
   assign rsp_last = (state == RDMPD_SEND) && (index + 8'h01 >= length);
endmodule

/* File: common/rdmpd_pkg.sv */
// Constants for the parameter description and device information responder
package rdmpd_pkg;
   // ==========================================
   // Request identifiers and message fields
   localparam logic [15:0] PID_PARAM_DESC = 16'h0050;
   localparam logic [15:0] PID_DEVICE_INFO = 16'h0060;
   localparam logic [15:0] MS_PID_LO = 16'h8000;
   localparam logic [15:0] MS_PID_HI = 16'hffdf;
   localparam logic [15:0] SUBDEV_MAX = 16'h0200;
   localparam logic [7:0] REQ_PDL_DESC = 8'h02;
   localparam logic [7:0] REQ_PDL_INFO = 8'h00;
   localparam logic [7:0] REQ_MSG_COUNT = 8'h00;
   // ==========================================
   // Response figures
   localparam logic [7:0] DESC_FIXED_LEN = 8'h14;
   localparam logic [7:0] DESC_MAX_LEN = 8'h34;
   localparam logic [5:0] LABEL_MAX = 6'h20;
   localparam logic [7:0] INFO_LEN = 8'h13;
   localparam logic [7:0] PROTO_MAJOR = 8'h01;
   localparam logic [7:0] PROTO_MINOR = 8'h00;
   localparam logic [7:0] OBSOLETE_TYPE = 8'h00;
   // ==========================================
   // Data type codes; limits carry no meaning for bit-field and text
   localparam logic [7:0] DS_BITFIELD = 8'h01;
   localparam logic [7:0] DS_TEXT = 8'h02;
   localparam logic [7:0] DS_U8 = 8'h03;
   localparam logic [7:0] DS_S8 = 8'h04;
   localparam logic [7:0] DS_U16 = 8'h05;
   localparam logic [7:0] DS_S16 = 8'h06;
   // ==========================================
   // Answer status codes
   localparam logic [1:0] ST_ACK = 2'h0;
   localparam logic [1:0] ST_NACK_RANGE = 2'h1;
   localparam logic [1:0] ST_NACK_FORMAT = 2'h2;
endpackage

/* File: rtl/rdmpd_byte_mux.sv */
// Selects one byte of a response record by index
module rdmpd_byte_mux #(
   parameter int NBYTES = 52
) (
   input wire logic [NBYTES*8-1:0] record, // Packed record, byte 0 in top bits
   input wire logic [7:0] index,           // Byte position
   output logic [7:0] data                 // Selected byte
);
   // ==========================================
   // Selection
   always_comb begin
      data = 8'h00;
      for (int i = 0; i < NBYTES; i++) begin
         if (index == 8'(i)) begin
            data = record[(NBYTES-1-i)*8 +: 8];
         end
      end
   end
endmodule

/* File: tb/rdmpd_sva.sv */
// Assertion checker for the description and device information responder
module rdmpd_sva (
   input wire logic sys_clk, // Clock
   input wire logic arst_n, // Reset
   input wire logic req_valid, // Request present
   input wire logic req_ready, // Request accepted
   input wire logic [15:0] req_pid, // Parameter asked
   input wire logic rsp_start, // Answer begins
   input wire logic [1:0] rsp_status, // Answer status
   input wire logic [7:0] rsp_pdl, // Answer length
   input wire logic rsp_valid, // Byte valid
   input wire logic rsp_ready, // Byte taken
   input wire logic [7:0] rsp_byte, // Data byte
   input wire logic rsp_last // Final byte
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // ==========================================
   // Byte position and answer kind
   logic [7:0] idx, next_idx;
   logic is_info, next_is_info;
   always_comb begin
      next_idx = idx;
      next_is_info = is_info;
      if (req_valid && req_ready) next_is_info = req_pid == rdmpd_pkg::PID_DEVICE_INFO;
      if (rsp_start) next_idx = 8'h00;
      else if (rsp_valid && rsp_ready) next_idx = idx + 8'h01;
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         idx <= 8'h00;
         is_info <= 1'h0;
      end else begin
         idx <= next_idx;
         is_info <= next_is_info;
      end
   end
   // ==========================================
   // Properties
   sequence s_take;
      req_valid && req_ready &&
         (req_pid == rdmpd_pkg::PID_PARAM_DESC || req_pid == rdmpd_pkg::PID_DEVICE_INFO);
   endsequence
   sequence s_ack(logic info);
      rsp_start && rsp_status == rdmpd_pkg::ST_ACK && is_info == info;
   endsequence
   property p_answer; s_take |=> rsp_start && !req_ready; endproperty
   property p_pulse; rsp_start |=> !rsp_start; endproperty
   property p_desc_len; s_ack(1'h0) |-> rsp_pdl >= 8'h14 && rsp_pdl <= 8'h34; endproperty
   property p_info_len; s_ack(1'h1) |-> rsp_pdl == 8'h13; endproperty
   property p_major; s_ack(1'h1) |=> rsp_valid && rsp_byte == 8'h01; endproperty
   property p_nack; rsp_start && rsp_status != 2'h0 |-> rsp_pdl == 8'h00 ##1 !rsp_valid;
   endproperty
   property p_hold;
      rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte) && $stable(rsp_last);
   endproperty
   property p_minor; rsp_valid && is_info && idx == 8'h01 |-> rsp_byte == 8'h00; endproperty
   property p_obsolete; rsp_valid && !is_info && idx == 8'h05 |-> rsp_byte == 8'h00; endproperty
   property p_last; rsp_valid && rsp_ready && rsp_last |-> idx + 8'h01 == rsp_pdl ##1 req_ready;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer after request");
   a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
   a_desc_len: assert property (p_desc_len) else $error("description length");
   a_info_len: assert property (p_info_len) else $error("info length");
   a_major: assert property (p_major) else $error("major version byte");
   a_nack: assert property (p_nack) else $error("refusal carries data");
   a_hold: assert property (p_hold) else $error("byte changed while stalled");
   a_minor: assert property (p_minor) else $error("minor version byte");
   a_obsolete: assert property (p_obsolete) else $error("obsolete byte not zero");
   a_last: assert property (p_last) else $error("last byte misplaced");
endmodule

bind rdmpd_responder rdmpd_sva u_sva (.sys_clk(sys_clk), .arst_n(arst_n),
   .req_valid(req_valid), .req_ready(req_ready), .req_pid(req_pid), .rsp_start(rsp_start),
   .rsp_status(rsp_status), .rsp_pdl(rsp_pdl), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
   .rsp_byte(rsp_byte), .rsp_last(rsp_last));

/* File: tb/rdmpd_framer.sv */
// Framer model that collects answer bytes, optionally stalling
module rdmpd_framer (
   input wire logic sys_clk, // Clock
   input wire logic arst_n, // Reset
   input wire logic stall, // Take one byte in four
   input wire logic rsp_start, // Answer begins
   input wire logic rsp_valid, // Byte valid
   input wire logic [7:0] rsp_byte, // Data byte
   output logic rsp_ready // Byte taken
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] got [64];
   logic [7:0] n;
   logic [1:0] ph;
   assign rsp_ready = !stall || ph == 2'h3;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         n <= 8'h00;
         ph <= 2'h0;
      end else begin
         ph <= ph + 2'h1;
         if (rsp_start) n <= 8'h00;
         else if (rsp_valid && rsp_ready) begin
            got[n[5:0]] <= rsp_byte;
            n <= n + 8'h01;
         end
      end
   end
endmodule

/* File: tb/rdm_param_desc_device_info_bench.sv */
// Self-checking bench for the description and device information responder
module rdm_param_desc_device_info_bench;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [15:0] pid, sub, dat; logic [7:0] pdl, cnt, typ, len;
      logic [5:0] ll; logic [1:0] st; logic kn;} rdmpd_row_t;
   // Requests with lookup results, then expected status and length
   rdmpd_row_t rows [13] = '{
      '{16'h50, 16'h0, 16'h8000, 8'h2, 8'h0, 8'h5, 8'h14, 6'h0, 2'h0, 1'h1},
      '{16'h50, 16'h0, 16'hffdf, 8'h2, 8'h0, 8'h3, 8'h34, 6'h20, 2'h0, 1'h1},
      '{16'h50, 16'h0, 16'h9000, 8'h2, 8'h0, 8'h2, 8'h19, 6'h5, 2'h0, 1'h1},
      '{16'h50, 16'h0, 16'hc000, 8'h2, 8'h0, 8'h1, 8'h15, 6'h1, 2'h0, 1'h1},
      '{16'h50, 16'h0, 16'h7fff, 8'h2, 8'h0, 8'h5, 8'h0, 6'h0, 2'h1, 1'h1},
      '{16'h50, 16'h0, 16'hffe0, 8'h2, 8'h0, 8'h5, 8'h0, 6'h0, 2'h1, 1'h1},
      '{16'h60, 16'h0, 16'h0, 8'h0, 8'h0, 8'h5, 8'h13, 6'h0, 2'h0, 1'h1},
      '{16'h60, 16'h200, 16'h0, 8'h0, 8'h0, 8'h5, 8'h13, 6'h0, 2'h0, 1'h1},
      '{16'h60, 16'h201, 16'h0, 8'h0, 8'h0, 8'h5, 8'h0, 6'h0, 2'h2, 1'h1},
      '{16'h60, 16'h0, 16'h0, 8'h0, 8'h1, 8'h5, 8'h0, 6'h0, 2'h2, 1'h1},
      '{16'h60, 16'h0, 16'h0, 8'h2, 8'h0, 8'h5, 8'h0, 6'h0, 2'h2, 1'h1},
      '{16'h50, 16'h0, 16'ha000, 8'h2, 8'h0, 8'h5, 8'h0, 6'h0, 2'h1, 1'h0},
      '{16'h50, 16'h0, 16'h8001, 8'h1, 8'h0, 8'h5, 8'h0, 6'h0, 2'h2, 1'h1}};
   logic sys_clk = 1'h0, arst_n = 1'h0, req_valid = 1'h0, desc_known = 1'h0, stall = 1'h0;
   logic req_ready, rsp_start, rsp_valid, rsp_ready, rsp_last;
   logic [15:0] req_pid = 16'h0, req_subdev = 16'h0, req_data = 16'h0, desc_pid;
   logic [7:0] req_pdl = 8'h0, req_msg_count = 8'h0, desc_type = 8'h0, rsp_pdl, rsp_byte;
   logic [1:0] rsp_status;
   logic [5:0] desc_label_len = 6'h0;
   logic [255:0] desc_label;
   logic [31:0] v = 32'h0;
   logic [135:0] info_rec = 136'h0;
   int miscompares = 0, total_checks = 0, cycles = 0;
   always #12.5 sys_clk = ~sys_clk;
   rdmpd_responder #(.LABEL_CHARS(32)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
      .req_valid(req_valid), .req_ready(req_ready), .req_pid(req_pid), .req_pdl(req_pdl),
      .req_msg_count(req_msg_count), .req_subdev(req_subdev), .req_data(req_data),
      .desc_pid(desc_pid), .desc_known(desc_known), .desc_size(v[7:0]), .desc_type(desc_type),
      .desc_class(v[15:8]), .desc_unit(v[23:16]), .desc_prefix(v[31:24]),
      .desc_min(32'hab000010), .desc_max(32'h00cd00f0), .desc_default(32'h12340080),
      .desc_label_len(desc_label_len), .desc_label(desc_label), .info_model(info_rec[135:120]),
      .info_category(info_rec[119:104]), .info_sw_version(info_rec[103:72]),
      .info_footprint(info_rec[71:56]), .info_personality(info_rec[55:40]),
      .info_start_addr(info_rec[39:24]), .info_subdev_count(info_rec[23:8]),
      .info_sensor_count(info_rec[7:0]), .rsp_start(rsp_start), .rsp_status(rsp_status),
      .rsp_pdl(rsp_pdl), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_byte(rsp_byte),
      .rsp_last(rsp_last));
   rdmpd_framer frm (.sys_clk(sys_clk), .arst_n(arst_n), .stall(stall), .rsp_start(rsp_start),
      .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_ready(rsp_ready));
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         miscompares++;
         $display("ERROR %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask
   task tally_and_finish;
      if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [415:0] rec_of(input rdmpd_row_t r);
      logic [31:0] m;
      m = r.typ < 8'h3 ? 32'h0 : (r.typ < 8'h5 ? 32'hff : 32'hffff);
      if (r.pid == 16'h60) return {8'h01, 8'h00, info_rec, 264'h0};
      return {r.dat, v[7:0], r.typ, v[15:8], 8'h00, v[23:16], v[31:24], 32'hab000010 & m,
         32'h00cd00f0 & m, 32'h12340080 & m, desc_label};
   endfunction
   // Issue one request, then check the answer header and every byte
   task automatic run(input rdmpd_row_t r, input logic [31:0] val, input logic slow);
      logic [415:0] x;
      int k;
      @(posedge sys_clk);
      {stall, v, req_valid, req_pid, req_subdev, req_data} <= {slow, val, 1'h1, r.pid, r.sub, r.dat};
      {req_pdl, req_msg_count, desc_type, desc_label_len, desc_known} <=
         {r.pdl, r.cnt, r.typ, r.ll, r.kn};
      info_rec <= {val[7:0], val, ~val, val[15:0], val[31:16], val ^ 32'h0f0f0f0f};
      @(posedge sys_clk);
      req_valid <= 1'h0;
      #1 chk(desc_pid, r.dat);
      chk(rsp_start, 1'h1);
      chk(rsp_status, r.st);
      chk(rsp_pdl, r.len);
      for (k = 0; k < 400 && req_ready !== 1'h1; k++) begin
         @(posedge sys_clk);
         #1;
      end
      chk(frm.n, r.len);
      x = rec_of(r);
      for (k = 0; k < r.len; k++) chk(frm.got[k], x[415 - 8 * k -: 8]);
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      for (int i = 0; i < 32; i++) desc_label[255 - 8 * i -: 8] = 8'h41 + 8'(i);
      repeat (20) @(posedge sys_clk);
      chk(req_ready, 1'h1);
      chk(rsp_valid, 1'h0);
      arst_n <= 1'h1;
      for (int i = 0; i < 26; i++) run(rows[i % 13], 32'h1a2b3c4d ^ {4{8'(i)}}, 1'(i / 13));
      // Reset in the middle of a stalled answer, then answer again
      run(rows[3], 32'h55aa33cc, 1'h1);
      @(posedge sys_clk);
      {req_valid, req_pid, req_pdl, req_msg_count, req_subdev} <= {1'h1, 16'h60, 16'h0, 16'h0};
      @(posedge sys_clk);
      req_valid <= 1'h0;
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'h0;
      #1 chk(rsp_valid, 1'h0);
      chk(req_ready, 1'h1);
      @(posedge sys_clk);
      arst_n <= 1'h1;
      run(rows[7], 32'h0badcafe, 1'h0);
      tally_and_finish();
   end
endmodule
